// ---- rtl/hlb_pkg.sv ----
// package: constants for the host link and boot option loader
package hlb_pkg;
  localparam longint CLK_HZ = 100000000;
  localparam int MENU_TMO_S = 20;
  localparam logic [31:0] MENU_TMO_CYC = 32'(MENU_TMO_S * CLK_HZ);
  // rate index 0..7 = 9600 .. 921600 bps
  localparam logic [2:0] BAUD_RST_IDX = 3'h4;
  localparam logic [2:0] BAUD_FAST_IDX = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST = 4'h8;
  localparam logic [2:0] SPI_LAST = 3'h7;
  localparam logic [7:0] RATE_REQ = 8'h1c;
  localparam logic [7:0] RATE_ACK = 8'h55;
  // option record: word[15:8] options, word[7:0] checksum
  localparam logic [7:0] CSUM_KEY = 8'ha5;
  localparam logic [7:0] OPT_CLEARED = 8'h00;
  localparam int OPT_BYPASS_BIT = 0;
  localparam int OPT_IMG_LSB = 4;
  localparam logic ADDR_PRI = 1'b0;
  localparam logic ADDR_BAK = 1'b1;
  localparam logic [7:0] ERR_CHR_RESTORED = 8'h52;
  localparam logic [7:0] ERR_CHR_CLEARED = 8'h46;
  localparam logic [3:0] MENU_LAST = 4'h9;

  function automatic logic [13:0] hlb_div(input logic [2:0] idx);
    case (idx)
      3'h0: return 14'(CLK_HZ / 9600);
      3'h1: return 14'(CLK_HZ / 19200);
      3'h2: return 14'(CLK_HZ / 38400);
      3'h3: return 14'(CLK_HZ / 57600);
      3'h4: return 14'(CLK_HZ / 115200);
      3'h5: return 14'(CLK_HZ / 230400);
      3'h6: return 14'(CLK_HZ / 460800);
      default: return 14'(CLK_HZ / 921600);
    endcase
  endfunction : hlb_div

  function automatic logic [7:0] hlb_menu_chr(input logic [3:0] idx, input logic [7:0] err_chr);
    case (idx)
      4'h0: return err_chr;
      4'h1: return 8'h0d;
      4'h2: return 8'h0a;
      4'h3: return 8'h31;
      4'h4: return 8'h41;
      4'h5: return 8'h42;
      4'h6: return 8'h53;
      4'h7: return 8'h4b;
      4'h8: return 8'h37;
      default: return 8'h3e;
    endcase
  endfunction : hlb_menu_chr

  typedef enum logic [13:0] {
    S_IDLE = 14'h0001, S_RD_PRI = 14'h0002, S_CHK_PRI = 14'h0004, S_RD_BAK = 14'h0008,
    S_CHK_BAK = 14'h0010, S_WR_PRI = 14'h0020, S_WR_BAK = 14'h0040, S_DECIDE = 14'h0080,
    S_MEASURE = 14'h0100, S_ACK = 14'h0200, S_LOCK = 14'h0400, S_MSG = 14'h0800,
    S_WAIT = 14'h1000, S_RUN = 14'h2000
  } hlb_state_t;
endpackage : hlb_pkg

// ---- rtl/hlb_opt_mem.sv ----
// two-word store for the primary and backup option records
`timescale 1ns/1ps
`default_nettype none
module hlb_opt_mem (
  // clock
  input wire logic clk_i,
  // access
  input wire logic we_i,
  input wire logic addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  // no reset: contents model nonvolatile storage
  logic [15:0] mem [0:1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : hlb_opt_mem
`default_nettype wire

// ---- rtl/hlb_top.sv ----
// host link front end: spi slave, uart with rate detection, boot option loader
// Functional notes
// RL1: spi port is a four-wire slave only
// RL2: interrupt high while output data pending; code raises it in spi mode only, it stays low in uart mode
// RL3: host treats interrupt as active-high level
// RL4: uart supports eight rates 9600 to 921600
// RL5: 8 data bits, no parity, one stop
// RL6: uart starts at 115200 before detection
// RL7: menu shown only after rate detection succeeds
// RL8: bad primary options restored from good backup
// RL9: both copies bad clears all options
// RL10: failure disables bypass, reports distinct error
// RL11: bypass loads default image, else host drives
// RL12: text menu on uart, commands on spi
// RL13: answer 0x1c with 0x55, lock on 0x55
// RL14: no choice in twenty seconds loads default
// RL15: options kept twice, each with checksum
`timescale 1ns/1ps
`default_nettype none
module hlb_top import hlb_pkg::*; #(
  parameter logic [31:0] MENU_TMO = MENU_TMO_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // boot control
  input wire logic boot_start_i,
  input wire logic host_if_spi_i,
  input wire logic opt_wr_i,
  input wire logic [7:0] opt_i,
  // raw option store preload
  input wire logic nv_we_i,
  input wire logic nv_addr_i,
  input wire logic [15:0] nv_wdata_i,
  // spi slave
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic spi_irq_o,
  // uart
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  // output buffer toward host
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  output logic out_ready_o,
  // bytes from host
  output logic host_valid_o,
  output logic [7:0] host_data_o,
  // status
  output logic boot_go_o,
  output logic [3:0] boot_img_o,
  output logic bypass_o,
  output logic err_restored_o,
  output logic err_cleared_o,
  output logic [2:0] baud_sel_o,
  output logic baud_locked_o,
  output logic boot_done_o
);
  // ************************************************************
  // option store and boot sequencer
  // ************************************************************
  hlb_state_t state, next_state;
  logic [7:0] rec, next_rec;
  logic err_r, next_err_r, err_c, next_err_c, upd, next_upd, go, next_go;
  logic locked, next_locked, done, next_done, hv, next_hv;
  logic [7:0] hd, next_hd;
  logic [2:0] baud, next_baud;
  logic [3:0] midx, next_midx;
  logic [31:0] wcnt, next_wcnt;
  logic [15:0] mcnt, next_mcnt;
  logic mem_we, mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic rd_ok, tx_start, hb_v;
  logic [7:0] tx_byte, hb_d;
  logic [13:0] div;
  logic [17:0] thr;
  // uart and spi state
  logic rx_q, rx_busy, next_rx_busy, rx_v, next_rx_v;
  logic [3:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
  logic [13:0] rx_div, next_rx_div, tx_div, next_tx_div;
  logic [7:0] rx_sh, next_rx_sh;
  logic tx_busy, next_tx_busy, tx_line, next_tx_line, tx_done;
  logic [9:0] tx_sh, next_tx_sh;
  logic sclk_q, cs_q, spi_load, next_spi_load, spi_v, next_spi_v, spi_oe, irq;
  logic [2:0] spi_cnt, next_spi_cnt;
  logic [7:0] spi_rx, next_spi_rx, spi_tx, next_spi_tx;
  logic spi_rise, spi_fall, spi_reload, spi_take;

  hlb_opt_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  assign rd_ok = (mem_rdata[7:0] == (mem_rdata[15:8] ^ CSUM_KEY));
  assign div = hlb_div(baud);
  assign hb_v = host_if_spi_i ? spi_v : rx_v;
  assign hb_d = host_if_spi_i ? spi_rx : rx_sh;

  always_comb begin
    next_state = state;
    next_rec = rec;
    next_err_r = err_r;
    next_err_c = err_c;
    next_upd = upd;
    next_go = 1'b0;
    next_locked = locked;
    next_done = done;
    next_hv = 1'b0;
    next_hd = hd;
    next_baud = baud;
    next_midx = midx;
    next_wcnt = wcnt;
    next_mcnt = mcnt;
    mem_we = 1'b0;
    mem_addr = ADDR_PRI;
    mem_wdata = {rec, rec ^ CSUM_KEY}; // see RL15
    tx_start = 1'b0;
    tx_byte = out_data_i;
    thr = 18'h0;
    case (state)
      S_IDLE: begin
        if (nv_we_i) begin
          mem_we = 1'b1;
          mem_addr = nv_addr_i;
          mem_wdata = nv_wdata_i;
        end else if (opt_wr_i) begin
          next_rec = opt_i;
          next_upd = 1'b1;
          next_state = S_WR_PRI;
        end else if (boot_start_i) begin
          next_state = S_RD_PRI;
        end
      end
      S_RD_PRI: next_state = S_CHK_PRI;
      S_CHK_PRI: begin
        mem_addr = ADDR_BAK;
        next_rec = mem_rdata[15:8];
        next_state = rd_ok ? S_DECIDE : S_RD_BAK; // see RL8
      end
      S_RD_BAK: begin
        mem_addr = ADDR_BAK;
        next_state = S_CHK_BAK;
      end
      S_CHK_BAK: begin
        // a bypass flag must not survive a failed check
        if (rd_ok) begin
          next_rec = mem_rdata[15:8] & ~(8'h01 << OPT_BYPASS_BIT); // see RL8, RL10
          next_err_r = 1'b1; // see RL10
        end else begin
          next_rec = OPT_CLEARED; // see RL9
          next_err_c = 1'b1; // see RL10
        end
        next_state = S_WR_PRI;
      end
      S_WR_PRI: begin
        mem_we = 1'b1; // see RL8
        next_state = S_WR_BAK;
      end
      S_WR_BAK: begin
        mem_we = 1'b1; // see RL15
        mem_addr = ADDR_BAK;
        next_upd = 1'b0;
        next_state = upd ? (done ? S_RUN : S_IDLE) : S_DECIDE;
      end
      S_DECIDE: begin
        next_wcnt = 32'h0;
        next_mcnt = 16'h0;
        if (rec[OPT_BYPASS_BIT] && !err_r && !err_c) begin
          next_go = 1'b1; // see RL11
          next_done = 1'b1;
          next_state = S_RUN;
        end else begin
          next_state = host_if_spi_i ? S_WAIT : S_MEASURE; // see RL12
        end
      end
      S_MEASURE: begin
        // start bit plus the two low data bits of 0x1c span three bit times
        if (!uart_rx_i && mcnt != 16'hffff) begin
          next_mcnt = mcnt + 16'h1;
        end else if (uart_rx_i && !rx_q && mcnt != 16'h0) begin
          next_baud = BAUD_FAST_IDX;
          for (int i = 7; i >= 0; i--) begin
            thr = 18'(({4'h0, hlb_div(3'(i))} * 18'h9) >> 2);
            if ({2'h0, mcnt} >= thr) begin
              next_baud = 3'(i); // see RL4, RL13
            end
          end
          next_state = S_ACK;
        end
      end
      S_ACK: begin
        tx_byte = RATE_ACK; // see RL13
        tx_start = !tx_busy;
        if (tx_done) begin
          next_state = S_LOCK;
        end
      end
      S_LOCK: begin
        if (rx_v) begin
          next_mcnt = 16'h0;
          if (rx_sh == RATE_ACK) begin
            next_locked = 1'b1; // see RL13
            next_midx = (err_r || err_c) ? 4'h0 : 4'h1;
            next_state = S_MSG; // see RL7
          end else begin
            // a retried request restarts the measurement
            next_state = S_MEASURE;
          end
        end
      end
      S_MSG: begin
        tx_byte = hlb_menu_chr(midx, err_r ? ERR_CHR_RESTORED : ERR_CHR_CLEARED); // see RL10, RL12
        tx_start = !tx_busy;
        if (tx_done) begin
          next_midx = midx + 4'h1;
          if (midx == MENU_LAST) begin
            next_state = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        next_wcnt = wcnt + 32'h1;
        if (hb_v) begin
          next_hv = 1'b1;
          next_hd = hb_d;
          next_done = 1'b1;
          next_state = S_RUN;
        end else if (wcnt == MENU_TMO - 32'h1) begin
          next_go = 1'b1; // see RL14
          next_done = 1'b1;
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        next_hv = hb_v;
        next_hd = hb_v ? hb_d : hd;
        tx_start = !host_if_spi_i && out_valid_i && !tx_busy;
        if (opt_wr_i) begin
          next_rec = opt_i;
          next_upd = 1'b1;
          next_state = S_WR_PRI;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
      rec <= OPT_CLEARED;
      err_r <= 1'b0;
      err_c <= 1'b0;
      upd <= 1'b0;
      go <= 1'b0;
      locked <= 1'b0;
      done <= 1'b0;
      hv <= 1'b0;
      hd <= 8'h00;
      baud <= BAUD_RST_IDX; // see RL6
      midx <= 4'h0;
      wcnt <= 32'h0;
      mcnt <= 16'h0;
    end else begin
      state <= next_state;
      rec <= next_rec;
      err_r <= next_err_r;
      err_c <= next_err_c;
      upd <= next_upd;
      go <= next_go;
      locked <= next_locked;
      done <= next_done;
      hv <= next_hv;
      hd <= next_hd;
      baud <= next_baud;
      midx <= next_midx;
      wcnt <= next_wcnt;
      mcnt <= next_mcnt;
    end
  end

  // ************************************************************
  // uart 8n1, no flow control
  // ************************************************************
  assign tx_done = tx_busy && tx_div == 14'h0 && tx_cnt == FRAME_LAST;

  always_comb begin
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt;
    next_rx_div = rx_div;
    next_rx_sh = rx_sh;
    next_rx_v = 1'b0;
    if (state == S_MEASURE || (state == S_ACK && tx_cnt < DATA_LAST)) begin
      // the tail of the rate request is still on the line; listening now reads a false byte
      next_rx_busy = 1'b0;
    end else if (!rx_busy) begin
      if (rx_q && !uart_rx_i) begin
        next_rx_busy = 1'b1;
        next_rx_cnt = 4'h0;
        next_rx_div = div >> 1;
      end
    end else if (rx_div != 14'h0) begin
      next_rx_div = rx_div - 14'h1;
    end else begin
      next_rx_div = div - 14'h1;
      next_rx_cnt = rx_cnt + 4'h1;
      if (rx_cnt == 4'h0) begin
        next_rx_busy = !uart_rx_i;
      end else if (rx_cnt <= DATA_LAST) begin
        next_rx_sh = {uart_rx_i, rx_sh[7:1]}; // see RL5
      end else begin
        next_rx_busy = 1'b0;
        next_rx_v = uart_rx_i; // see RL5
      end
    end
  end

  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_cnt = tx_cnt;
    next_tx_div = tx_div;
    next_tx_sh = tx_sh;
    next_tx_line = tx_line;
    if (tx_start) begin
      next_tx_busy = 1'b1;
      next_tx_sh = {1'b1, tx_byte, 1'b0}; // see RL5
      next_tx_line = 1'b0;
      next_tx_cnt = 4'h0;
      next_tx_div = div - 14'h1;
    end else if (tx_busy && tx_div != 14'h0) begin
      next_tx_div = tx_div - 14'h1;
    end else if (tx_busy) begin
      if (tx_cnt == FRAME_LAST) begin
        next_tx_busy = 1'b0;
        next_tx_line = 1'b1;
      end else begin
        next_tx_sh = {1'b1, tx_sh[9:1]};
        next_tx_line = tx_sh[1];
        next_tx_cnt = tx_cnt + 4'h1;
        next_tx_div = div - 14'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_q <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= 4'h0;
      rx_div <= 14'h0;
      rx_sh <= 8'h00;
      rx_v <= 1'b0;
      tx_busy <= 1'b0;
      tx_cnt <= 4'h0;
      tx_div <= 14'h0;
      tx_sh <= 10'h3ff;
      tx_line <= 1'b1;
    end else begin
      rx_q <= uart_rx_i;
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_div <= next_rx_div;
      rx_sh <= next_rx_sh;
      rx_v <= next_rx_v;
      tx_busy <= next_tx_busy;
      tx_cnt <= next_tx_cnt;
      tx_div <= next_tx_div;
      tx_sh <= next_tx_sh;
      tx_line <= next_tx_line;
    end
  end

  // ************************************************************
  // spi slave, mode 0, msb first
  // ************************************************************
  assign spi_rise = spi_sclk_i && !sclk_q && !spi_cs_n_i;
  assign spi_fall = !spi_sclk_i && sclk_q && !spi_cs_n_i;
  assign spi_reload = (cs_q && !spi_cs_n_i) || (spi_fall && spi_load);
  assign spi_take = host_if_spi_i && spi_reload && out_valid_i;
  assign out_ready_o = host_if_spi_i ? spi_take : (state == S_RUN && tx_start);

  always_comb begin
    next_spi_cnt = spi_cnt;
    next_spi_rx = spi_rx;
    next_spi_tx = spi_tx;
    next_spi_load = spi_load;
    next_spi_v = 1'b0;
    if (spi_cs_n_i) begin
      next_spi_cnt = 3'h0; // see RL1
      next_spi_load = 1'b0;
    end else if (spi_rise) begin
      next_spi_rx = {spi_rx[6:0], spi_mosi_i};
      next_spi_cnt = spi_cnt + 3'h1;
      if (spi_cnt == SPI_LAST) begin
        next_spi_v = 1'b1;
        next_spi_load = 1'b1;
      end
    end
    if (spi_reload) begin
      // idle filler is zero when nothing is pending
      next_spi_tx = spi_take ? out_data_i : 8'h00;
      next_spi_load = 1'b0;
    end else if (spi_fall) begin
      next_spi_tx = {spi_tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      spi_cnt <= 3'h0;
      spi_rx <= 8'h00;
      spi_tx <= 8'h00;
      spi_load <= 1'b0;
      spi_v <= 1'b0;
      spi_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_i;
      cs_q <= spi_cs_n_i;
      spi_cnt <= next_spi_cnt;
      spi_rx <= next_spi_rx;
      spi_tx <= next_spi_tx;
      spi_load <= next_spi_load;
      spi_v <= next_spi_v;
      spi_oe <= !spi_cs_n_i; // see RL1
      irq <= host_if_spi_i && out_valid_i; // see RL2, RL3
    end
  end

  assign spi_miso_o = spi_tx[7];
  assign spi_miso_oe_o = spi_oe;
  assign spi_irq_o = irq;
  assign uart_tx_o = tx_line;
  assign host_valid_o = hv;
  assign host_data_o = hd;
  assign boot_go_o = go;
  assign boot_img_o = rec[OPT_IMG_LSB +: 4];
  assign bypass_o = rec[OPT_BYPASS_BIT];
  assign err_restored_o = err_r;
  assign err_cleared_o = err_c;
  assign baud_sel_o = baud;
  assign baud_locked_o = locked;
  assign boot_done_o = done;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_irq_level: assert property (host_if_spi_i && out_valid_i |=> spi_irq_o) else $error("irq low with data"); // see RL2
  a_irq_drop: assert property (!out_valid_i |=> !spi_irq_o) else $error("irq high without data"); // see RL2
  a_cs_release: assert property (spi_cs_n_i |=> !spi_miso_oe_o) else $error("miso driven while deselected"); // see RL1
  a_rate_reset: assert property (state == S_DECIDE |-> baud_sel_o == BAUD_RST_IDX) else $error("rate not default"); // see RL6
  a_menu_locked: assert property (state == S_MSG |-> baud_locked_o && !host_if_spi_i) else $error("menu early"); // see RL7, RL12
  a_copy_back: assert property (state == S_CHK_BAK && rd_ok |=> mem_we && mem_addr == ADDR_PRI ##1 mem_we && mem_addr == ADDR_BAK) else $error("backup not restored"); // see RL8
  a_total_clear: assert property (state == S_CHK_BAK && !rd_ok |=> rec == OPT_CLEARED && err_cleared_o && !err_restored_o) else $error("options not cleared"); // see RL9
  a_fail_bypass: assert property ((err_restored_o || err_cleared_o) && state == S_DECIDE |-> !bypass_o ##1 !boot_go_o) else $error("bypass after failure"); // see RL10
  a_bypass_go: assert property (state == S_DECIDE && bypass_o && !err_restored_o && !err_cleared_o |=> boot_go_o && state == S_RUN) else $error("bypass did not load"); // see RL11
  a_menu_tmo: assert property (state == S_WAIT && wcnt == MENU_TMO - 32'h1 && !hb_v |=> boot_go_o) else $error("timeout lost"); // see RL14
  a_ack_char: assert property (state == S_ACK && tx_start |-> tx_byte == RATE_ACK ##1 !uart_tx_o) else $error("bad rate answer"); // see RL13
  a_frame_stop: assert property (tx_done |=> uart_tx_o && !tx_busy) else $error("no stop bit"); // see RL5
  a_rec_csum: assert property (mem_we && !nv_we_i |-> mem_wdata[7:0] == (mem_wdata[15:8] ^ CSUM_KEY)) else $error("checksum not stored"); // see RL15

  c_restored: cover property (state == S_CHK_BAK && rd_ok);
  c_cleared: cover property (state == S_CHK_BAK && !rd_ok);
  c_locked: cover property ($rose(baud_locked_o));
  c_timeout: cover property (state == S_WAIT ##1 boot_go_o);
endmodule : hlb_top
`default_nettype wire

// ---- verif/hlb_host_model.sv ----
// host microcontroller model: uart side of the host link
`timescale 1ns/1ps
`default_nettype none
module hlb_host_model (
  // clock
  input wire logic clk_i,
  // uart lines
  output logic tx_o,
  input wire logic rx_i
);
  // ****************
  // host uart
  // ****************
  int div = 868;
  logic [7:0] rxq[$];
  initial tx_o = 1'b1;
  // 8n1, lsb first, no flow control; line idles high after the stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 10; i++) begin
      tx_o = f[i];
      repeat (div) @(posedge clk_i);
      #1;
    end
  endtask : send_byte
  // mid-bit sampling; a frame with a bad stop bit is dropped
  always begin : rx_proc
    logic [7:0] b;
    @(negedge rx_i);
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_i);
      b[i] = rx_i;
    end
    repeat (div) @(posedge clk_i);
    if (rx_i === 1'b1) rxq.push_back(b);
  end
endmodule : hlb_host_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the host link front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hlb_pkg::*;
  // ****************
  // signals
  // ****************
  localparam logic [31:0] TMO = 32'h0000_07d0;
  typedef struct packed {
    logic [15:0] pri; logic [15:0] bak; logic pre; logic byp; logic rst; logic clr; logic [3:0] img;
  } hlb_row_t;
  hlb_row_t rows[4];
  logic clk = 1'b0, rstn = 1'b0, boot_start = 1'b0, host_if_spi = 1'b1;
  logic nv_we = 1'b0, nv_addr = 1'b0, sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0, rx_line, out_valid = 1'b0;
  logic [15:0] nv_wdata = 16'h0000;
  logic [7:0] out_data = 8'h00, opt = 8'h00, host_data, mi, d;
  logic opt_wr = 1'b0;
  logic miso, miso_oe, irq, uart_tx, out_ready, host_valid, go, bypass, err_r, err_c, locked, done;
  logic [3:0] img;
  logic [2:0] baud_sel;
  int failures = 0, compares = 0, n;
  always #5 clk = ~clk;
  hlb_top #(.MENU_TMO(TMO)) i_hlb_top (.clk_i(clk), .rstn_i(rstn), .boot_start_i(boot_start),
    .host_if_spi_i(host_if_spi), .opt_wr_i(opt_wr), .opt_i(opt), .nv_we_i(nv_we), .nv_addr_i(nv_addr),
    .nv_wdata_i(nv_wdata), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .spi_irq_o(irq), .uart_rx_i(rx_line), .uart_tx_o(uart_tx),
    .out_valid_i(out_valid), .out_data_i(out_data), .out_ready_o(out_ready), .host_valid_o(host_valid),
    .host_data_o(host_data), .boot_go_o(go), .boot_img_o(img), .bypass_o(bypass), .err_restored_o(err_r),
    .err_cleared_o(err_c), .baud_sel_o(baud_sel), .baud_locked_o(locked), .boot_done_o(done));
  hlb_host_model i_hlb_host_model (.clk_i(clk), .tx_o(rx_line), .rx_i(uart_tx));
  // ****************
  // tasks
  // ****************
  function automatic logic [15:0] good(input logic [7:0] o);
    return {o, o ^ CSUM_KEY};
  endfunction : good
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // the store is not reset, so a boot without preload sees what the last boot left
  task automatic boot(input logic [15:0] p, input logic [15:0] b, input logic pre, input logic s);
    host_if_spi = s;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    check("baud_rst", 16'(baud_sel), 16'h0004);
    check("tx_idle", 16'(uart_tx), 16'h0001);
    nv_we = pre;
    nv_addr = ADDR_PRI;
    nv_wdata = p;
    @(posedge clk);
    #1;
    nv_addr = ADDR_BAK;
    nv_wdata = b;
    @(posedge clk);
    #1;
    nv_we = 1'b0;
    boot_start = 1'b1;
    @(posedge clk);
    #1;
    boot_start = 1'b0;
  endtask : boot
  task automatic wait_for(input int w, input int max, output int k, output logic [7:0] dv);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (k < max && (w ? host_valid : go) !== 1'b1);
    dv = host_data;
  endtask : wait_for
  task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] r);
    cs_n = 1'b0;
    #1;
    check("out_ready", 16'(out_ready), 16'h0001);
    repeat (4) @(posedge clk);
    #1;
    for (int i = 7; i >= 0; i--) begin
      mosi = mo[i];
      repeat (4) @(posedge clk);
      #1;
      r[i] = miso;
      sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      sclk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1;
    check("miso_oe", 16'(miso_oe), 16'h0001);
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask : spi_xfer
  // ****************
  // tests
  // ****************
  initial begin
    #1_000_000;
    failures++;
    stop_test();
  end
  initial begin
    rows[0] = '{good(8'h31), good(8'h00), 1'b1, 1'b1, 1'b0, 1'b0, 4'h3};
    rows[1] = '{16'h3100, good(8'h51), 1'b1, 1'b0, 1'b1, 1'b0, 4'h5};
    rows[2] = '{16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5};
    rows[3] = '{16'h3100, 16'h5100, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0};
    for (int r = 0; r < 4; r++) begin
      boot(rows[r].pri, rows[r].bak, rows[r].pre, 1'b1);
      wait_for(0, 2400, n, d);
      if (r == 0) check("go_delay", 16'(n), 16'h0004);
      else check("go_tmo", 16'(n > 2000 && n < 2400), 16'h0001);
      check("bypass", 16'(bypass), 16'(rows[r].byp));
      check("err_r", 16'(err_r), 16'(rows[r].rst));
      check("err_c", 16'(err_c), 16'(rows[r].clr));
      check("img", 16'(img), 16'(rows[r].img));
      check("done", 16'(done), 16'h0001);
      $display("test row %0d done", r);
    end
    // detection at the fastest rate after a backup restore
    boot(16'h4000, good(8'h40), 1'b1, 1'b0);
    i_hlb_host_model.div = 108;
    out_valid = 1'b1;
    // the host leaves the device time to finish its option check first
    repeat (20) @(posedge clk);
    i_hlb_host_model.send_byte(RATE_REQ);
    for (n = 0; n < 3000 && i_hlb_host_model.rxq.size() == 0; n++) @(posedge clk);
    check("rate_ack", 16'(i_hlb_host_model.rxq[0]), 16'h0055);
    check("baud_fast", 16'(baud_sel), 16'h0007);
    check("not_locked", 16'(locked), 16'h0000);
    check("irq_uart", 16'(irq), 16'h0000);
    out_valid = 1'b0;
    i_hlb_host_model.send_byte(RATE_ACK);
    for (n = 0; n < 14000 && i_hlb_host_model.rxq.size() < 11; n++) @(posedge clk);
    check("locked", 16'(locked), 16'h0001);
    check("menu_err", 16'(i_hlb_host_model.rxq[1]), 16'(ERR_CHR_RESTORED));
    check("menu_cr", 16'(i_hlb_host_model.rxq[2]), 16'h000d);
    fork
      i_hlb_host_model.send_byte(8'h41);
      wait_for(1, 2000, n, d);
    join
    check("host_byte", 16'(d), 16'h0041);
    $display("test uart done");
    // spi exchange while waiting for a host choice
    boot(good(8'h20), good(8'h20), 1'b1, 1'b1);
    repeat (10) @(posedge clk);
    #1;
    out_valid = 1'b1;
    out_data = 8'ha6;
    repeat (2) @(posedge clk);
    #1;
    check("irq_hi", 16'(irq), 16'h0001);
    fork
      spi_xfer(8'hc3, mi);
      wait_for(1, 200, n, d);
    join
    check("miso", 16'(mi), 16'h00a6);
    check("mosi", 16'(d), 16'h00c3);
    check("irq_level", 16'(irq), 16'h0001);
    out_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("irq_lo", 16'(irq), 16'h0000);
    check("miso_off", 16'(miso_oe), 16'h0000);
    $display("test spi done");
    // an option update in run rewrites both copies, so a plain reboot boots from it
    opt = 8'h71;
    opt_wr = 1'b1;
    @(posedge clk);
    #1;
    opt_wr = 1'b0;
    repeat (4) @(posedge clk);
    boot(16'h0000, 16'h0000, 1'b0, 1'b1);
    wait_for(0, 50, n, d);
    check("upd_go", 16'(n), 16'h0004);
    check("upd_img", 16'(img), 16'h0007);
    check("upd_bypass", 16'(bypass), 16'h0001);
    $display("test update done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
